// ---- tmr_pkg.sv ----
// Constants for the 16-bit timer/event counter with edge inputs.
// Assumes an APB master on pclk; offsets are byte addresses of 32-bit words.
package tmr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] OUTC_OFS   = 8'h04;
  localparam logic [7:0] PRESC_OFS  = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_CLRST_BIT = 1;
  localparam int CTRL_PINOUT_BIT = 2;
  localparam int OUTC_INV1_BIT  = 0;
  localparam int OUTC_INV2_BIT  = 1;
  localparam int OUTC_OE_BIT    = 2;
  localparam int OUTC_OSP_BIT   = 3;
  localparam int OUTC_LVS_BIT   = 4;
  localparam int OUTC_LVR_BIT   = 5;
  localparam int PRESC_CLK_LSB  = 0;
  localparam int PRESC_E0_LSB   = 2;
  localparam int PRESC_E1_LSB   = 4;
  localparam int ST_E0_BIT      = 0;
  localparam int ST_E1_BIT      = 1;
  localparam int ST_TO_BIT      = 2;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CLK_DIV1   = 2'h0;
  localparam logic [1:0] CLK_DIV4   = 2'h1;
  localparam logic [1:0] CLK_DIV16  = 2'h2;
  localparam logic [1:0] CLK_EDGE0  = 2'h3;
  localparam logic [1:0] EDGE_FALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_NONE  = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;
  localparam logic [5:0] PRESC_RST  = 6'h00;
  localparam logic [3:0] OUTC_RST   = 4'h0;
  localparam logic [2:0] CTRL_RST   = 3'h0;
  localparam logic [3:0] DIV4_TERM  = 4'h3;
  localparam logic [3:0] DIV16_TERM = 4'hf;

endpackage : tmr_pkg

// ---- edge_sampler.sv ----
// Three-stage input sampler with edge detection for one capture pin.
// Assumes an asynchronous pin; edge is valid when stages two and three agree.
`timescale 1ns/1ns
module edge_sampler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pin,
  input  wire logic       run,
  input  wire logic [1:0] edge_sel,
  output logic            level,
  output logic            edge_det
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       lvl_reg;
  logic       lvl_next;
  logic       armed_reg;
  logic       armed_next;
  logic       run_q_reg;
  logic       run_q_next;
  logic       rise;
  logic       fall;

  // ---------------------------------------------------------------
  // Sampling and edge detection
  // ---------------------------------------------------------------
  always_comb begin
    sync_next  = {sync_reg[1:0], pin};
    lvl_next   = lvl_reg;
    armed_next = armed_reg;
    run_q_next = run;
    rise       = 1'b0;
    fall       = 1'b0;
    if (sync_reg[1] == sync_reg[2])
      lvl_next = sync_reg[2];
    if (run && !run_q_reg && armed_reg) begin
      rise       = lvl_next;
      armed_next = 1'b0;
    end else if (run && !run_q_reg) begin
      rise = 1'b0;
    end else begin
      rise = lvl_next & ~lvl_reg;
      fall = ~lvl_next & lvl_reg;
    end
    if (!run) begin
      rise = 1'b0;
      fall = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg  <= 3'h0;
      lvl_reg   <= 1'b0;
      armed_reg <= 1'b1;
      run_q_reg <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      lvl_reg   <= lvl_next;
      armed_reg <= armed_next;
      run_q_reg <= run_q_next;
    end
  end

  assign level = lvl_reg;
  always_comb begin
    unique case (edge_sel)
      tmr_pkg::EDGE_FALL: edge_det = fall;
      tmr_pkg::EDGE_RISE: edge_det = rise;
      tmr_pkg::EDGE_BOTH: edge_det = rise | fall;
      tmr_pkg::EDGE_NONE: edge_det = 1'b0;
    endcase
  end

  property p_reenable_quiet;
    @(posedge pclk) disable iff (!presetn)
      (run && !run_q_reg && !armed_reg) |-> !edge_det;
  endproperty
  a_reenable_quiet: assert property (p_reenable_quiet) else $error("edge at re-enable");

  property p_first_enable;
    @(posedge pclk) disable iff (!presetn)
      (run && !run_q_reg && armed_reg && (sync_reg[1] == sync_reg[2]) && sync_reg[2]
       && edge_sel == tmr_pkg::EDGE_RISE) |-> edge_det;
  endproperty
  a_first_enable: assert property (p_first_enable) else $error("missed first rise");

  property p_filter;
    @(posedge pclk) disable iff (!presetn)
      (sync_reg[1] != sync_reg[2]) |=> $stable(lvl_reg);
  endproperty
  a_filter: assert property (p_filter) else $error("level moved without agreement");

endmodule : edge_sampler

// ---- tmr_core.sv ----
// Timer/event counter core with APB register slave and shared output pin.
// Assumes an APB master on pclk and asynchronous capture input pins.
`timescale 1ns/1ns
module tmr_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_capture_input,
  input  wire logic        shared_port_pin_in,
  output logic             shared_port_pin_out,
  output logic             shared_port_pin_oen
);

  logic [2:0]  ctrl_reg;
  logic [2:0]  ctrl_next;
  logic [3:0]  outc_reg;
  logic [3:0]  outc_next;
  logic [5:0]  presc_reg;
  logic [5:0]  presc_next;
  logic [15:0] up_counter_reg;
  logic [15:0] up_counter_next;
  logic [3:0]  div_reg;
  logic [3:0]  div_next;
  logic        tout_reg;
  logic        tout_next;
  logic [1:0]  sticky_reg;
  logic [1:0]  sticky_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        perr_reg;
  logic        perr_next;
  logic        e0_det;
  logic        e1_det;
  logic        e0_lvl;
  logic        e1_lvl;
  logic        run;
  logic        pin_is_out;
  logic        tick;
  logic        wr;
  logic        rd;
  logic        hit;
  logic        lvs_wr;
  logic        lvr_wr;

  assign run        = ctrl_reg[tmr_pkg::CTRL_RUN_BIT];
  assign pin_is_out = ctrl_reg[tmr_pkg::CTRL_PINOUT_BIT];
  assign wr         = psel && penable && pwrite;
  assign rd         = psel && penable && !pwrite;
  assign pready     = 1'b1;
  assign prdata     = prdata_reg;
  assign pslverr    = perr_reg;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == tmr_pkg::CTRL_OFS) || (a == tmr_pkg::OUTC_OFS) ||
               (a == tmr_pkg::PRESC_OFS) || (a == tmr_pkg::COUNT_OFS) ||
               (a == tmr_pkg::STATUS_OFS);
  endfunction : addr_hit

  assign hit = addr_hit(paddr);

  // ---------------------------------------------------------------
  // Edge inputs
  // ---------------------------------------------------------------
  edge_sampler u_e0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (first_capture_input),
    .run      (run),
    .edge_sel (presc_reg[tmr_pkg::PRESC_E0_LSB +: 2]),
    .level    (e0_lvl),
    .edge_det (e0_det)
  );

  edge_sampler u_e1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (shared_port_pin_in & ~pin_is_out),
    .run      (run & ~pin_is_out),
    .edge_sel (presc_reg[tmr_pkg::PRESC_E1_LSB +: 2]),
    .level    (e1_lvl),
    .edge_det (e1_det)
  );

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_next  = ctrl_reg;
    outc_next  = outc_reg;
    presc_next = presc_reg;
    lvs_wr     = 1'b0;
    lvr_wr     = 1'b0;
    if (wr) begin
      unique case (paddr)
        tmr_pkg::CTRL_OFS:  ctrl_next = pwdata[2:0];
        tmr_pkg::OUTC_OFS: begin
          outc_next = pwdata[3:0];
          lvs_wr = pwdata[tmr_pkg::OUTC_LVS_BIT];
          lvr_wr = pwdata[tmr_pkg::OUTC_LVR_BIT];
        end
        tmr_pkg::PRESC_OFS: begin
          if (!run)
            presc_next = pwdata[5:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= tmr_pkg::CTRL_RST;
      outc_reg  <= tmr_pkg::OUTC_RST;
      presc_reg <= tmr_pkg::PRESC_RST;
    end else begin
      ctrl_reg  <= ctrl_next;
      outc_reg  <= outc_next;
      presc_reg <= presc_next;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  always_comb begin
    div_next        = run ? div_reg + 4'h1 : 4'h0;
    up_counter_next = up_counter_reg;
    tick            = 1'b0;
    unique case (presc_reg[tmr_pkg::PRESC_CLK_LSB +: 2])
      tmr_pkg::CLK_DIV1:  tick = run;
      tmr_pkg::CLK_DIV4:  tick = run && (div_reg[1:0] == tmr_pkg::DIV4_TERM[1:0]);
      tmr_pkg::CLK_DIV16: tick = run && (div_reg == tmr_pkg::DIV16_TERM);
      tmr_pkg::CLK_EDGE0: tick = e0_det;
    endcase
    if (!run)
      up_counter_next = 16'h0000;
    else if (ctrl_reg[tmr_pkg::CTRL_CLRST_BIT] && e0_det &&
             presc_reg[1:0] != tmr_pkg::CLK_EDGE0)
      up_counter_next = 16'h0000;
    else if (tick)
      up_counter_next = up_counter_reg + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg        <= 4'h0;
      up_counter_reg <= 16'h0000;
    end else begin
      div_reg        <= div_next;
      up_counter_reg <= up_counter_next;
    end
  end

  // ---------------------------------------------------------------
  // Output flip-flop and edge status
  // ---------------------------------------------------------------
  always_comb begin
    tout_next   = tout_reg;
    sticky_next = sticky_reg;
    if (run && tick && up_counter_reg == 16'hffff &&
        (outc_reg[tmr_pkg::OUTC_INV1_BIT] || outc_reg[tmr_pkg::OUTC_INV2_BIT]))
      tout_next = ~tout_reg;
    if (lvs_wr)
      tout_next = 1'b1;
    else if (lvr_wr)
      tout_next = 1'b0;
    if (rd && paddr == tmr_pkg::STATUS_OFS)
      // Clear only the edges that this read reported
      sticky_next = sticky_reg & ~prdata_reg[1:0];
    // Set wins over read-clear
    if (e0_det)
      sticky_next[0] = 1'b1;
    if (e1_det)
      sticky_next[1] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_reg   <= 1'b0;
      sticky_reg <= 2'h0;
    end else begin
      tout_reg   <= tout_next;
      sticky_reg <= sticky_next;
    end
  end

  assign shared_port_pin_out = tout_reg;
  assign shared_port_pin_oen = ~(pin_is_out & outc_reg[tmr_pkg::OUTC_OE_BIT]);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    prdata_next = prdata_reg;
    perr_next   = 1'b0;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      perr_next   = !hit;
      if (!pwrite) begin
        unique case (paddr)
          tmr_pkg::CTRL_OFS:   prdata_next = {29'h0, ctrl_reg};
          tmr_pkg::OUTC_OFS:   prdata_next = {28'h0, outc_reg};
          tmr_pkg::PRESC_OFS:  prdata_next = {26'h0, presc_reg};
          tmr_pkg::COUNT_OFS:  prdata_next = {16'h0, up_counter_reg};
          tmr_pkg::STATUS_OFS: prdata_next = {27'h0, e1_lvl, e0_lvl, tout_reg, sticky_reg};
          default:             prdata_next = 32'h0000_0000;
        endcase
      end
    end else if (psel && penable) begin
      perr_next = perr_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      perr_reg   <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      perr_reg   <= perr_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_presc_hold;
    @(posedge pclk) disable iff (!presetn)
      run |=> (presc_reg == $past(presc_reg));
  endproperty
  a_presc_hold: assert property (p_presc_hold) else $error("prescaler changed while running");

  property p_lvl_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == tmr_pkg::OUTC_OFS) |=> (prdata[5:4] == 2'h0);
  endproperty
  a_lvl_zero: assert property (p_lvl_zero) else $error("level bits read nonzero");

  sequence s_set_write;
    wr && paddr == tmr_pkg::OUTC_OFS && pwdata[tmr_pkg::OUTC_LVS_BIT];
  endsequence
  property p_force_high;
    @(posedge pclk) disable iff (!presetn) s_set_write |=> tout_reg;
  endproperty
  a_force_high: assert property (p_force_high) else $error("level set not applied");

  property p_pin_role;
    @(posedge pclk) disable iff (!presetn) !shared_port_pin_oen |-> pin_is_out;
  endproperty
  a_pin_role: assert property (p_pin_role) else $error("pin driven while input");

  property p_stop_clear;
    @(posedge pclk) disable iff (!presetn) !run |=> (up_counter_reg == 16'h0000);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared");

  sequence s_reset_write;
    wr && paddr == tmr_pkg::OUTC_OFS && pwdata[tmr_pkg::OUTC_LVR_BIT] &&
      !pwdata[tmr_pkg::OUTC_LVS_BIT];
  endsequence
  property p_force_low;
    @(posedge pclk) disable iff (!presetn) s_reset_write |=> !tout_reg;
  endproperty
  a_force_low: assert property (p_force_low) else $error("level reset not applied");

  property p_input_off;
    @(posedge pclk) disable iff (!presetn) pin_is_out |-> !e1_det;
  endproperty
  a_input_off: assert property (p_input_off) else $error("edge seen while pin is output");

  property p_presc_refused;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == tmr_pkg::PRESC_OFS && run) |=> $stable(presc_reg);
  endproperty
  a_presc_refused: assert property (p_presc_refused) else $error("prescaler write taken");

  property p_edge_kept;
    @(posedge pclk) disable iff (!presetn) e0_det |=> sticky_reg[0];
  endproperty
  a_edge_kept: assert property (p_edge_kept) else $error("first input edge lost");

  property p_e1_kept;
    @(posedge pclk) disable iff (!presetn) e1_det |=> sticky_reg[1];
  endproperty
  a_e1_kept: assert property (p_e1_kept) else $error("second input edge lost");

  property p_edge_count;
    @(posedge pclk) disable iff (!presetn)
      (run && presc_reg[tmr_pkg::PRESC_CLK_LSB +: 2] == tmr_pkg::CLK_EDGE0 && e0_det &&
       up_counter_reg != 16'hffff)
      |=> (up_counter_reg == $past(up_counter_reg) + 16'h0001);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("input edge not counted");

endmodule : tmr_core

// ---- edge_src.sv ----
// Edge sources standing outside the timer on both capture pins.
// Assumes the bench resolves the shared pin from these drives and the design's enable.
`timescale 1ns/1ns
module edge_src (
  input  wire logic pclk,
  input  wire logic oen,
  output logic      cap0,
  output logic      cap1_drv,
  output logic      cap1_en
);
  logic lvl1;

  initial begin
    cap0 = 1'b1;
    lvl1 = 1'b0;
  end

  assign cap1_en  = oen;
  // Inverted stale value, so a released line never looks driven
  assign cap1_drv = oen ? lvl1 : ~lvl1;

  task automatic set_pin(input int idx, input logic val);
    @(posedge pclk);
    if (idx == 0) begin
      cap0 <= val;
    end else begin
      lvl1 <= val;
    end
  endtask : set_pin

  task automatic glitch();
    @(posedge pclk);
    lvl1 <= ~lvl1;
    @(posedge pclk);
    lvl1 <= ~lvl1;
  endtask : glitch
endmodule : edge_src

// ---- tb_top.sv ----
// Self-checking bench for the timer core: APB master, edge sources, random cases.
// Assumes tmr_pkg, edge_sampler, tmr_core and edge_src are compiled first.
`timescale 1ns/1ns
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cap0;
  logic        cap1_drv;
  logic        cap1_en;
  logic        pin_wire;
  logic        pin_out;
  logic        pin_oen;
  logic [31:0] r;
  logic        e;
  logic [31:0] v;
  logic [1:0]  m;
  integer      seed;
  int          err_count;
  int          comparisons;

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Shared pin: design when enabled, else source, else pull-up
  assign pin_wire = (pin_oen === 1'b0) ? pin_out : (cap1_en ? cap1_drv : 1'b1);

  tmr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_capture_input(cap0), .shared_port_pin_in(pin_wire),
    .shared_port_pin_out(pin_out), .shared_port_pin_oen(pin_oen));

  edge_src src (.pclk(pclk), .oen(pin_oen), .cap0(cap0), .cap1_drv(cap1_drv),
    .cap1_en(cap1_en));

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      end_sim();
    end else begin
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rdm(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & msk, x);
  endtask : rdm

  function automatic logic exp_edge(input logic [1:0] md, input logic rising);
    if (rising) begin
      return md == tmr_pkg::EDGE_RISE || md == tmr_pkg::EDGE_BOTH;
    end
    return md == tmr_pkg::EDGE_FALL || md == tmr_pkg::EDGE_BOTH;
  endfunction : exp_edge

  initial begin
    #2000000;
    err_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // count clock derived from pclk, or taken from first-input edges (CLK_EDGE0)
  // clear-start only with a pclk-derived count clock
  initial begin
    seed = 40;
    err_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, pin_oen}, 32'h1);
    rdm(tmr_pkg::CTRL_OFS, 32'hffffffff, {29'h0, tmr_pkg::CTRL_RST});
    rdm(tmr_pkg::OUTC_OFS, 32'hffffffff, {28'h0, tmr_pkg::OUTC_RST});
    rdm(tmr_pkg::PRESC_OFS, 32'hffffffff, {26'h0, tmr_pkg::PRESC_RST});
    apb(1'b0, 8'h14, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, tmr_pkg::PRESC_OFS, {26'h0, tmr_pkg::EDGE_FALL, tmr_pkg::EDGE_RISE,
      tmr_pkg::CLK_DIV1});
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    rdm(tmr_pkg::STATUS_OFS, 32'h1, 32'h1);
    apb(1'b0, tmr_pkg::COUNT_OFS, 32'h0);
    chk({31'h0, r[15:0] != 16'h0}, 32'h1);
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h0);
    rdm(tmr_pkg::COUNT_OFS, 32'hffff, 32'h0);
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    rdm(tmr_pkg::STATUS_OFS, 32'h1, 32'h0);
    repeat (6) begin
      v = $random(seed);
      apb(1'b1, tmr_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, tmr_pkg::PRESC_OFS, {26'h0, v[5:0]});
      rdm(tmr_pkg::PRESC_OFS, 32'h3f, {26'h0, v[5:0]});
      apb(1'b1, tmr_pkg::CTRL_OFS, 32'h1);
      apb(1'b1, tmr_pkg::PRESC_OFS, ~v);
      rdm(tmr_pkg::PRESC_OFS, 32'h3f, {26'h0, v[5:0]});
      apb(1'b1, tmr_pkg::OUTC_OFS, {28'h0, v[9:6]});
      rdm(tmr_pkg::OUTC_OFS, 32'hffffffff, {28'h0, v[9:6]});
    end
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      apb(1'b1, tmr_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, tmr_pkg::PRESC_OFS, {26'h0, m, tmr_pkg::EDGE_NONE, tmr_pkg::CLK_DIV1});
      apb(1'b0, tmr_pkg::STATUS_OFS, 32'h0);
      apb(1'b1, tmr_pkg::CTRL_OFS, 32'h1);
      src.set_pin(1, 1'b1);
      repeat (8) @(posedge pclk);
      rdm(tmr_pkg::STATUS_OFS, 32'h2, {30'h0, exp_edge(m, 1'b1), 1'b0});
      src.set_pin(1, 1'b0);
      repeat (8) @(posedge pclk);
      rdm(tmr_pkg::STATUS_OFS, 32'h2, {30'h0, exp_edge(m, 1'b0), 1'b0});
    end
    src.glitch();
    repeat (8) @(posedge pclk);
    rdm(tmr_pkg::STATUS_OFS, 32'h2, 32'h0);
    // Clear-start on a first input edge, count clock divided from pclk
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, tmr_pkg::PRESC_OFS, {26'h0, tmr_pkg::EDGE_NONE, tmr_pkg::EDGE_FALL,
      tmr_pkg::CLK_DIV4});
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h3);
    repeat (40) @(posedge pclk);
    apb(1'b0, tmr_pkg::COUNT_OFS, 32'h0);
    v = r;
    src.set_pin(0, 1'b0);
    repeat (8) @(posedge pclk);
    apb(1'b0, tmr_pkg::COUNT_OFS, 32'h0);
    chk({31'h0, r[15:0] < v[15:0]}, 32'h1);
    // Counting filtered rising edges of the first input
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, tmr_pkg::PRESC_OFS, {26'h0, tmr_pkg::EDGE_NONE, tmr_pkg::EDGE_RISE,
      tmr_pkg::CLK_EDGE0});
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h1);
    repeat (2) begin
      src.set_pin(0, 1'b1);
      repeat (8) @(posedge pclk);
      src.set_pin(0, 1'b0);
      repeat (8) @(posedge pclk);
    end
    rdm(tmr_pkg::COUNT_OFS, 32'hffff, 32'h2);
    apb(1'b1, tmr_pkg::OUTC_OFS, 32'h0);
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h5);
    apb(1'b1, tmr_pkg::OUTC_OFS, 32'h4);
    @(posedge pclk);
    chk({31'h0, pin_oen}, 32'h0);
    apb(1'b0, tmr_pkg::STATUS_OFS, 32'h0);
    apb(1'b1, tmr_pkg::OUTC_OFS, 32'h14);
    @(posedge pclk);
    chk({30'h0, pin_oen, pin_out}, 32'h1);
    repeat (8) @(posedge pclk);
    rdm(tmr_pkg::STATUS_OFS, 32'h2, 32'h0);
    rdm(tmr_pkg::OUTC_OFS, 32'hffffffff, 32'h4);
    apb(1'b1, tmr_pkg::OUTC_OFS, 32'h24);
    @(posedge pclk);
    chk({30'h0, pin_oen, pin_out}, 32'h0);
    rdm(tmr_pkg::OUTC_OFS, 32'hffffffff, 32'h4);
    apb(1'b1, tmr_pkg::CTRL_OFS, 32'h0);
    @(posedge pclk);
    chk({31'h0, pin_oen}, 32'h1);
    end_sim();
  end
endmodule : tb_top
